// File: design/wdog_core.sv
// Process data watchdog with fault response on the digital outputs.
// Assumes a 16-bit register port on the module clock from the protocol server.
// Contract
// - Fault mode codes: standard 0, reset 1, hold 2; reset mode after reset.
// - Standard or reset fault response drives all outputs to zero.
// - Hold fault response keeps outputs at their value at detection.
// - Fault mode written at word 2002 or byte address 4004.
// - After reset the watchdog is enabled with a 500 ms timeout.
// - Timeout 200 to 65000 ms, written at word 2000 or byte 4000.
// - Unarmed until the first output write, which arms and starts it.
// - Every output write restarts the timeout from zero.
// - Reads never arm or restart the watchdog.
// - Expiry applies fault response and sets the network fail flag.
// - Setting the flag stores a reason code at word 6, byte 12.
// - Once armed the watchdog cannot be stopped.
// - Outputs stay in fault state until the fault is acknowledged.
// - Acknowledge clears the flag and restarts the watchdog.
// - Acknowledge is command 0x0002 at word 2006 or byte 4012.
// - Timeout zero disables the watchdog, only while still unarmed.
// - Codes 0x000C expiry, 0x000D fieldbus, 0x0007 byte iface, 0x0008 host.
// - Codes 0x0001-0x0006 internal, 0x0009 user, 0x000A abort, 0x000B init.
`timescale 1ns/10ps
module wdog_core #(
    parameter int unsigned CYC_PER_MS = wdog_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_byte_mode,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Other monitors
    input wire logic mon_fail,
    input wire logic [15:0] mon_reason,
    // Outputs and status
    output logic [15:0] dig_out,
    output logic network_fail_flag
);
    // ********************************************
    // Address decode
    // ********************************************
    // Byte addresses are twice the word address; odd ones hit nothing
    function automatic logic hit(input logic [15:0] addr, input logic bmode,
                                 input logic [15:0] word);
        hit = bmode ? (addr == {word[14:0], 1'b0}) : (addr == word);
    endfunction

    wire wr_out = reg_wr && hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_OUT_DATA);
    wire wr_tmo = reg_wr && hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_TIMEOUT);
    wire wr_mode = reg_wr && hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_FAULT_MODE);
    wire wr_test = reg_wr && hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_FAIL_TEST);
    wire wr_cmd = reg_wr && hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_COMMAND);
    wire ack = wr_cmd && (reg_wdata == wdog_pkg::CMD_ACK);

    // ********************************************
    // Registers and state
    // ********************************************
    wdog_pkg::wd_state_t state_r, state_nxt;
    wdog_pkg::fault_mode_t mode_r;
    logic [15:0] timeout_r;
    logic [15:0] reason_r;
    logic [15:0] shadow_r;
    logic [15:0] dout_r;
    logic [15:0] cmd_r;
    logic flag_r;
    logic [15:0] rdata_r;
    logic rvalid_r;

    // Timer link; the core owns restart, run and limit
    wdog_timer_if tif ();

    // Timeout value checks
    wire tmo_zero = (reg_wdata == 16'h0000);
    wire tmo_ok = (reg_wdata >= wdog_pkg::TIMEOUT_MIN_MS) &&
                  (reg_wdata <= wdog_pkg::TIMEOUT_MAX_MS);
    wire unarmed = (state_r == wdog_pkg::ST_INIT) || (state_r == wdog_pkg::ST_OFF);
    wire tmo_take = wr_tmo && (tmo_ok || (tmo_zero && unarmed));
    wire mode_ok = (reg_wdata <= 16'h0002);

    // Fault sources; the watchdog expiry wins over other monitors
    wire wd_expire = (state_r == wdog_pkg::ST_ARMED) && tif.expired;
    wire fail_evt = wd_expire || mon_fail || wr_test;
    wire [15:0] reason_nxt = wd_expire ? wdog_pkg::REASON_WATCHDOG_EXPIRED :
                             mon_fail ? mon_reason :
                             wdog_pkg::REASON_USER_FORCED;

    // ********************************************
    // Watchdog state machine
    // ********************************************
    // A fault taken in the same cycle as an acknowledge is kept
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            wdog_pkg::ST_INIT:
            begin
                if (fail_evt)
                    state_nxt = wdog_pkg::ST_FAULT;
                else if (tmo_take && tmo_zero)
                    state_nxt = wdog_pkg::ST_OFF;
                else if (wr_out)
                    state_nxt = wdog_pkg::ST_ARMED;
            end
            wdog_pkg::ST_ARMED:
            begin
                if (fail_evt)
                    state_nxt = wdog_pkg::ST_FAULT;
            end
            wdog_pkg::ST_FAULT:
            begin
                if (ack && !fail_evt)
                    state_nxt = (timeout_r == 16'h0000) ? wdog_pkg::ST_OFF :
                                wdog_pkg::ST_ARMED;
            end
            wdog_pkg::ST_OFF:
            begin
                if (fail_evt)
                    state_nxt = wdog_pkg::ST_FAULT;
                else if (tmo_take && !tmo_zero)
                    state_nxt = wdog_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state_r <= wdog_pkg::ST_INIT;
        else
            state_r <= state_nxt;
    end

    // ********************************************
    // Timer control
    // ********************************************
    // Restart on arming, on each output write, and after acknowledge
    assign tif.run = (state_r == wdog_pkg::ST_ARMED);
    assign tif.restart = (state_nxt == wdog_pkg::ST_ARMED) &&
                         (wr_out || state_r != wdog_pkg::ST_ARMED);
    // A limit written together with a restart is used at once
    assign tif.limit = tmo_take ? reg_wdata : timeout_r;

    wdog_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
        .clock(clock),
        .rst(rst),
        .tif(tif)
    );

    // ********************************************
    // Configuration registers
    // ********************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            timeout_r <= wdog_pkg::TIMEOUT_RESET_MS;
            mode_r <= wdog_pkg::FAULT_MODE_RESET;
            cmd_r <= 16'h0000;
        end
        else
        begin
            // Refused values leave the old setting in place
            if (tmo_take)
                timeout_r <= reg_wdata;
            if (wr_mode && mode_ok)
                mode_r <= wdog_pkg::fault_mode_t'(reg_wdata[1:0]);
            if (wr_cmd)
                cmd_r <= reg_wdata;
        end
    end

    // ********************************************
    // Fail flag and reason
    // ********************************************
    // Set beats acknowledge when both land in one cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            flag_r <= 1'b0;
            reason_r <= 16'h0000;
        end
        else if (fail_evt)
        begin
            flag_r <= 1'b1;
            reason_r <= reason_nxt;
        end
        else if (ack && state_r == wdog_pkg::ST_FAULT)
            flag_r <= 1'b0;
    end

    // ********************************************
    // Output data path
    // ********************************************
    // Writes during a fault land in the shadow and show after acknowledge
    wire entering_fault = (state_r != wdog_pkg::ST_FAULT) &&
                          (state_nxt == wdog_pkg::ST_FAULT);
    wire clear_outs = (mode_r != wdog_pkg::MODE_HOLD);
    wire [15:0] shadow_nxt = wr_out ? reg_wdata : shadow_r;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shadow_r <= 16'h0000;
            dout_r <= 16'h0000;
        end
        else
        begin
            shadow_r <= shadow_nxt;
            // Hold keeps the value last driven, not the shadow
            if (entering_fault)
                dout_r <= clear_outs ? 16'h0000 : dout_r;
            else if (state_nxt != wdog_pkg::ST_FAULT)
                dout_r <= shadow_nxt;
        end
    end

    // ********************************************
    // Read path
    // ********************************************
    // Unmapped and odd byte addresses read as zero
    wire [15:0] rd_mux =
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_OUT_DATA) ? shadow_r :
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_FAIL_REASON) ? reason_r :
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_TIMEOUT) ? timeout_r :
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_FAULT_MODE) ? {14'h0000, mode_r} :
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_FAIL_TEST) ? reason_r :
        hit(reg_addr, reg_byte_mode, wdog_pkg::ADDR_COMMAND) ? cmd_r : 16'h0000;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_rd;
            if (reg_rd)
                rdata_r <= rd_mux;
        end
    end

    assign rd_data = rdata_r;
    assign rd_valid = rvalid_r;
    assign dig_out = dout_r;
    assign network_fail_flag = flag_r;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Properties guard reset defaults, arming, timeout range and the fault path; bus timing is left to the bench

    reset_defaults_a: assert property ($fell(rst) |-> timeout_r == 16'h01F4 && mode_r == 2'b01)
        else $error("defaults wrong after reset");
    clear_mode_a: assert property (entering_fault && mode_r != 2'b10 |=> dout_r == 16'h0000)
        else $error("outputs not cleared on fault");
    hold_mode_a: assert property (entering_fault && mode_r == 2'b10 |=>
        dout_r == $past(dout_r) [*3])
        else $error("held outputs changed");
    first_write_arms_a: assert property (state_r == wdog_pkg::ST_INIT && wr_out && !fail_evt
        && !wr_tmo |=> state_r == wdog_pkg::ST_ARMED)
        else $error("first write did not arm");
    read_no_arm_a: assert property (state_r == wdog_pkg::ST_INIT && !reg_wr && !mon_fail
        |=> state_r == wdog_pkg::ST_INIT)
        else $error("read armed the watchdog");
    expiry_flag_a: assert property (wd_expire |=> flag_r && reason_r == 16'h000C
        && state_r == wdog_pkg::ST_FAULT)
        else $error("expiry not reported");
    armed_no_stop_a: assert property (state_r == wdog_pkg::ST_ARMED && wr_tmo && tmo_zero
        |=> timeout_r == $past(timeout_r) && state_r != wdog_pkg::ST_OFF)
        else $error("armed watchdog stopped");
    ack_clears_a: assert property (state_r == wdog_pkg::ST_FAULT && ack && !fail_evt
        |=> !flag_r)
        else $error("acknowledge did not clear flag");
    range_reject_a: assert property (wr_tmo && !tmo_zero && (reg_wdata < 16'h00C8 ||
        reg_wdata > 16'hFDE8) |=> timeout_r == $past(timeout_r))
        else $error("out of range timeout taken");
    fault_outputs_a: assert property (state_r == wdog_pkg::ST_FAULT && $past(state_r)
        == wdog_pkg::ST_FAULT |-> $stable(dout_r))
        else $error("outputs changed during fault");
    // Disable, re-arm, fault hold and reason bookkeeping
    reason_stored_a: assert property (mon_fail && !wd_expire |=> flag_r
        && reason_r == $past(mon_reason))
        else $error("monitor reason not stored");
    zero_disables_a: assert property (state_r == wdog_pkg::ST_INIT && wr_tmo && tmo_zero
        && !fail_evt |=> state_r == wdog_pkg::ST_OFF && timeout_r == 16'h0000)
        else $error("zero timeout did not disable");
    ack_rearms_a: assert property (state_r == wdog_pkg::ST_FAULT && ack && !fail_evt
        && timeout_r != 16'h0000 |=> state_r == wdog_pkg::ST_ARMED)
        else $error("acknowledge did not restart watchdog");
    fault_kept_a: assert property (state_r == wdog_pkg::ST_FAULT && !ack
        |=> state_r == wdog_pkg::ST_FAULT)
        else $error("fault left without acknowledge");
endmodule

// File: design/wdog_pkg.sv
// Constants shared by the process data watchdog and its millisecond timer.
// Assumes a 100 MHz clock and 16-bit register words.
package wdog_pkg;
    // ********************************************
    // Clock and timing
    // ********************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] TIMEOUT_RESET_MS = 16'h01F4;
    localparam logic [15:0] TIMEOUT_MIN_MS = 16'h00C8;
    localparam logic [15:0] TIMEOUT_MAX_MS = 16'hFDE8;

    // ********************************************
    // Register word addresses
    // ********************************************
    localparam logic [15:0] ADDR_OUT_DATA = 16'h0002;
    localparam logic [15:0] ADDR_FAIL_REASON = 16'h0006;
    localparam logic [15:0] ADDR_TIMEOUT = 16'h07D0;
    localparam logic [15:0] ADDR_FAULT_MODE = 16'h07D2;
    localparam logic [15:0] ADDR_FAIL_TEST = 16'h07D4;
    localparam logic [15:0] ADDR_COMMAND = 16'h07D6;
    localparam logic [15:0] CMD_ACK = 16'h0002;

    // ********************************************
    // Fault response modes and states
    // ********************************************
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'b00,
        MODE_RESET = 2'b01,
        MODE_HOLD = 2'b10
    } fault_mode_t;
    localparam fault_mode_t FAULT_MODE_RESET = MODE_RESET;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_ARMED = 2'b01,
        ST_FAULT = 2'b10,
        ST_OFF = 2'b11
    } wd_state_t;

    // ********************************************
    // Fail reason codes
    // ********************************************
    localparam logic [15:0] REASON_TASK_START_ERROR = 16'h0001;
    localparam logic [15:0] REASON_HOST_CTRL_ERROR = 16'h0006;
    localparam logic [15:0] REASON_BYTE_IFACE_TIMEOUT = 16'h0007;
    localparam logic [15:0] REASON_HOST_TIMEOUT = 16'h0008;
    localparam logic [15:0] REASON_USER_FORCED = 16'h0009;
    localparam logic [15:0] REASON_CONNECTION_ABORTED = 16'h000A;
    localparam logic [15:0] REASON_INIT_ERROR = 16'h000B;
    localparam logic [15:0] REASON_WATCHDOG_EXPIRED = 16'h000C;
    localparam logic [15:0] REASON_FIELDBUS_TIMEOUT = 16'h000D;
endpackage

// File: design/wdog_timer.sv
// Millisecond tick divider and timeout counter for the watchdog.
// Expects restart and run from the core on the same clock.
`timescale 1ns/10ps
module wdog_timer #(
    parameter int unsigned CYC_PER_MS = wdog_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Core link
    wdog_timer_if.tmr tif
);
    logic [31:0] div_r;
    logic [15:0] ms_r;
    logic [15:0] limit_r;
    logic expired_r;
    wire tick = (div_r == CYC_PER_MS - 1);
    wire [15:0] ms_nxt = ms_r + 16'h0001;

    // ********************************************
    // Tick and count
    // ********************************************
    // Restart clears the divider too, so every interval is a full one
    always_ff @(posedge clock)
    begin
        if (rst || tif.restart || !tif.run)
        begin
            div_r <= 32'h00000000;
            ms_r <= 16'h0000;
            expired_r <= 1'b0;
            if (rst)
                limit_r <= wdog_pkg::TIMEOUT_RESET_MS;
            else if (tif.restart)
                limit_r <= tif.limit;
        end
        else
        begin
            div_r <= tick ? 32'h00000000 : div_r + 32'h00000001;
            ms_r <= tick ? ms_nxt : ms_r;
            expired_r <= tick && (ms_nxt == limit_r);
        end
    end

    assign tif.expired = expired_r;
endmodule

// File: design/wdog_timer_if.sv
// Control link between the watchdog core and its millisecond timer.
// Both ends sit on the same clock.
`timescale 1ns/10ps
interface wdog_timer_if;
    logic restart;
    logic run;
    logic [15:0] limit;
    logic expired;
    modport ctl (output restart, output run, output limit, input expired);
    modport tmr (input restart, input run, input limit, output expired);
endinterface

// File: sim/client_model.sv
// Remote client model: single-word register writes and reads.
// Assumes the device samples its strobes on the rising clock edge.
`timescale 1ns/10ps
module client_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_byte_mode,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    // Read answer
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    // ****************
    // Access
    // ****************
    // Idle values at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_byte_mode = 1'b0;
        reg_addr = 16'hA5A5;
        reg_wdata = 16'h5A5A;
    end

    // One-cycle strobe; strobes drop to zero, released address, data and byte mode are inverted so late sampling sees junk
    task automatic access(input logic wr, input logic bm, input logic [15:0] a,
                          input logic [15:0] d);
        @(posedge clock);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_byte_mode <= bm;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_byte_mode <= ~bm;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // Read: the valid flag only stands for one cycle, so sample it at once
    task automatic read(input logic bm, input logic [15:0] a, output logic [15:0] d,
                        output logic v);
        access(1'b0, bm, a, 16'h0000);
        #1;
        d = rd_data;
        v = rd_valid;
    endtask
endmodule

// File: sim/wdog_core_tb.sv
// Self-checking bench for the process data watchdog core.
// Assumes a shortened millisecond tick; the client model drives the register port.
`timescale 1ns/10ps
module wdog_core_tb;
    // ****************
    // Setup
    // ****************
    localparam int CPM = 10;
    localparam int LIMIT = 40000;
    localparam logic [15:0] A_TMO = wdog_pkg::ADDR_TIMEOUT;
    localparam logic [15:0] A_OUT = wdog_pkg::ADDR_OUT_DATA;
    localparam logic [15:0] A_RSN = wdog_pkg::ADDR_FAIL_REASON;
    localparam logic [15:0] A_CMD = wdog_pkg::ADDR_COMMAND;
    logic clock;
    logic rst;
    logic mon_fail;
    logic [15:0] mon_reason;
    logic reg_wr;
    logic reg_rd;
    logic reg_byte_mode;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] dig_out;
    logic network_fail_flag;
    int n_mismatch;
    int checks;
    int cyc;
    logic [31:0] seed;
    logic [15:0] d;
    logic [15:0] codes [7] = '{16'h0001, 16'h0006, 16'h0007, 16'h0008, 16'h000A,
                               16'h000B, 16'h000D};

    client_model cli (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_byte_mode(reg_byte_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid));
    wdog_core #(.CYC_PER_MS(CPM)) dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_byte_mode(reg_byte_mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .mon_fail(mon_fail), .mon_reason(mon_reason), .dig_out(dig_out),
        .network_fail_flag(network_fail_flag));

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard: a stuck handshake must still reach the report
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    // Hold mode freezes outputs, the other modes clear them
    function automatic logic [15:0] fault_out(input logic [1:0] m, input logic [15:0] v);
        return (m == 2'b10) ? v : 16'h0000;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic exp);
        checks++;
        if (network_fail_flag !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: fail flag %b", $time, network_fail_flag);
        end
    endtask

    task automatic rchk(input logic bm, input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        cli.read(bm, a, v, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(v, exp);
    endtask

    task automatic owr(input logic [15:0] v);
        cli.access(1'b1, 1'b0, A_OUT, v);
        #1;
        chk(dig_out, v);
    endtask

    // Expiry window: quiet until just before the limit, set shortly after
    task automatic expire(input int ms, input int spent);
        int i;
        repeat (ms * CPM - 5 - spent) @(posedge clock);
        #1;
        chk_flag(1'b0);
        for (i = 0; i < 10 && network_fail_flag !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        chk_flag(1'b1);
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************
    // Sequence
    // ****************
    initial
    begin
        seed = 32'hD7EE;
        n_mismatch = 0;
        checks = 0;
        rst = 1'b1;
        mon_fail = 1'b0;
        mon_reason = 16'h0000;
        do_reset();
        rchk(1'b0, A_TMO, 16'h01F4);
        rchk(1'b0, wdog_pkg::ADDR_FAULT_MODE, 16'h0001);
        // Refused and boundary timeouts
        cli.access(1'b1, 1'b0, A_TMO, 16'h00C7);
        rchk(1'b1, 16'h0FA0, 16'h01F4);
        cli.access(1'b1, 1'b0, A_TMO, 16'hFDE9);
        rchk(1'b0, A_TMO, 16'h01F4);
        cli.access(1'b1, 1'b0, A_TMO, 16'hFDE8);
        rchk(1'b0, A_TMO, 16'hFDE8);
        cli.access(1'b1, 1'b1, 16'h0FA0, 16'h00C8);
        rchk(1'b0, A_TMO, 16'h00C8);
        cli.access(1'b1, 1'b0, wdog_pkg::ADDR_FAULT_MODE, 16'h0003);
        rchk(1'b0, wdog_pkg::ADDR_FAULT_MODE, 16'h0001);
        // Reads alone never arm
        repeat (4) rchk(1'b0, A_OUT, 16'h0000);
        repeat (2100) @(posedge clock);
        #1;
        chk_flag(1'b0);
        // Arm, try to stop, retrigger
        d = xs();
        owr(d);
        cli.access(1'b1, 1'b0, A_TMO, 16'h0000);
        rchk(1'b0, A_TMO, 16'h00C8);
        repeat (3)
        begin
            repeat (1500) @(posedge clock);
            d = xs();
            owr(d);
            chk_flag(1'b0);
        end
        repeat (1000) @(posedge clock);
        rchk(1'b0, A_OUT, d);
        expire(200, 1002);
        chk(dig_out, 16'h0000);
        rchk(1'b0, A_RSN, 16'h000C);
        rchk(1'b1, 16'h000C, 16'h000C);
        // Outputs held until acknowledged
        d = xs();
        cli.access(1'b1, 1'b0, A_OUT, d);
        #1;
        chk(dig_out, 16'h0000);
        cli.access(1'b1, 1'b0, A_CMD, 16'h0001);
        #1;
        chk_flag(1'b1);
        cli.access(1'b1, 1'b0, A_CMD, wdog_pkg::CMD_ACK);
        @(posedge clock);
        #1;
        chk_flag(1'b0);
        chk(dig_out, d);
        expire(200, 1);
        // Every fault mode, alternating word and byte addressing
        for (int m = 0; m < 3; m++)
        begin
            cli.access(1'b1, m[0], m[0] ? 16'h0FA4 : 16'h07D2, 16'(m));
            rchk(1'b0, wdog_pkg::ADDR_FAULT_MODE, 16'(m));
            cli.access(1'b1, m[0], m[0] ? 16'h0FAC : A_CMD, wdog_pkg::CMD_ACK);
            d = xs();
            owr(d);
            expire(200, 0);
            chk(dig_out, fault_out(m[1:0], d));
        end
        // Other fault causes record their own code
        foreach (codes[i])
        begin
            cli.access(1'b1, 1'b0, A_CMD, wdog_pkg::CMD_ACK);
            @(posedge clock);
            mon_fail <= 1'b1;
            mon_reason <= codes[i];
            @(posedge clock);
            mon_fail <= 1'b0;
            mon_reason <= ~codes[i];
            #1;
            chk_flag(1'b1);
            rchk(1'b0, A_RSN, codes[i]);
        end
        cli.access(1'b1, 1'b0, A_CMD, wdog_pkg::CMD_ACK);
        cli.access(1'b1, 1'b0, wdog_pkg::ADDR_FAIL_TEST, xs());
        rchk(1'b0, A_RSN, 16'h0009);
        rchk(1'b0, wdog_pkg::ADDR_FAIL_TEST, 16'h0009);
        rchk(1'b0, A_CMD, wdog_pkg::CMD_ACK);
        // Zero timeout while unarmed disables the watchdog
        do_reset();
        cli.access(1'b1, 1'b0, A_TMO, 16'h0000);
        rchk(1'b0, A_TMO, 16'h0000);
        owr(xs());
        repeat (5200) @(posedge clock);
        #1;
        chk_flag(1'b0);
        // A valid timeout brings it back to unarmed; the next write arms it
        cli.access(1'b1, 1'b0, A_TMO, 16'h00C8);
        rchk(1'b0, A_TMO, 16'h00C8);
        owr(xs());
        expire(200, 0);
        chk(dig_out, 16'h0000);
        tally_and_finish();
    end
endmodule
